/* File: rtl/dis_defs.vh */
// constants for the dac two-wire command port
`ifndef DIS_DEFS_VH
`define DIS_DEFS_VH
`define DIS_ADDR_FIXED 5'h15
`define DIS_BURST_PTR 8'hff
`define DIS_BYTE_BITS 4'h8
`define DIS_PTR_AB 7
`define DIS_PTR_RW 6
`define DIS_REG_HI 15
`define DIS_REG_LO 14
`define DIS_MON_HI 13
`define DIS_MON_LO 8
`define DIS_LAST_CH16 4'hf
`define DIS_LAST_CH8 4'h7
`define DIS_SFR_NOP 4'h0
`define DIS_SFR_CLRCODE 4'h1
`define DIS_SFR_SOFTCLR 4'h2
`define DIS_SFR_PDOWN 4'h8
`define DIS_SFR_PUP 4'h9
`define DIS_SFR_MON 4'ha
`define DIS_SFR_CTRL 4'hc
`define DIS_SFR_SRST 4'hf
`define DIS_CLR_RST 14'h0000
`define DIS_CTRL_RST 14'h0000
`define DIS_MON_RST 6'h00
// timer lengths in 20 ns clock cycles: 20 us, 15 us, 8 us
`define DIS_NOP_CYC 11'h001
`define DIS_CLR16_CYC 11'h3e8
`define DIS_CLR8_CYC 11'h2ee
`define DIS_PU_CYC 11'h190
`define DIS_TMR_W 11
`endif

/* File: rtl/dis_sync.v */
// three-flop pin synchroniser with agreement filter
`timescale 1ns/10ps
module dis_sync #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input wire mclk, // system clock
  input wire rstn, // async reset, active low
  input wire [W-1:0] d, // raw pin levels
  output wire [W-1:0] q // filtered levels
);
  genvar i;
  // --------------------------------------------------------------
  // per-bit chain
  // --------------------------------------------------------------
  generate
    for (i = 0; i < W; i = i + 1)
    begin : g_bit
      // each bit keeps its own stages, so every flop has one driver
      reg s1_ff;
      reg s2_ff;
      reg s3_ff;
      reg q_ff;
      // level only moves once stages two and three agree
      always @(posedge mclk or negedge rstn)
      begin
        if (!rstn)
        begin
          s1_ff <= INIT[i];
          s2_ff <= INIT[i];
          s3_ff <= INIT[i];
          q_ff <= INIT[i];
        end
        else
        begin
          s1_ff <= d[i];
          s2_ff <= s1_ff;
          s3_ff <= s2_ff;
          if (s2_ff == s3_ff)
            q_ff <= s3_ff;
        end
      end
      assign q[i] = q_ff;
    end
  endgenerate
endmodule // dis_sync

/* File: rtl/dis_tmr.v */
// load-and-count-down activity timer
`timescale 1ns/10ps
`include "dis_defs.vh"
module dis_tmr (
  input wire mclk, // system clock
  input wire rstn, // async reset, active low
  input wire load, // start pulse
  input wire [`DIS_TMR_W-1:0] val, // cycles to stay active
  output wire act // high for val cycles after load
);
  reg [`DIS_TMR_W-1:0] cnt_ff;
  reg act_ff;
  // a reload while running restarts the full interval
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_ff <= {`DIS_TMR_W{1'b0}};
      act_ff <= 1'b0;
    end
    else if (load)
    begin
      cnt_ff <= val;
      act_ff <= (val != {`DIS_TMR_W{1'b0}});
    end
    else
    begin
      if (cnt_ff != {`DIS_TMR_W{1'b0}})
        cnt_ff <= cnt_ff - {{(`DIS_TMR_W-1){1'b0}}, 1'b1};
      act_ff <= (cnt_ff > {{(`DIS_TMR_W-1){1'b0}}, 1'b1});
    end
  end
  assign act = act_ff;
endmodule // dis_tmr

/* File: rtl/dis_top.v */
// two-wire write-only command port with special command decoder
`timescale 1ns/10ps
`include "dis_defs.vh"
module dis_top (
  input wire mclk, // system clock, 50 MHz
  input wire rstn, // async reset, active low
  input wire scl_in, // bus clock pin level
  input wire sda_in, // bus data pin level
  output wire scl_out, // bus clock drive value
  output wire scl_oe, // bus clock drive enable
  output wire sda_out, // bus data drive value
  output wire sda_oe, // bus data drive enable
  input wire if_sel_spi, // interface select, low = two-wire
  input wire bus_addr_strap_hi, // address strap, bit 1
  input wire bus_addr_strap_lo, // address strap, bit 0
  input wire clear_pin_n, // clear pin, active low
  input wire pd_pin, // hardware power-down pin
  input wire variant_8ch, // high on eight-channel build
  input wire pd_hiz_cfg, // powered-down outputs float
  output wire dac_wr, // channel register write pulse
  output wire dac_ab, // toggle a/b select of write
  output wire [3:0] dac_ch, // channel of write
  output wire [1:0] dac_reg, // register select of write
  output wire [13:0] dac_data, // data word of write
  output wire clr_all, // load clear code to all dacs
  output wire [13:0] clr_code, // clear code register
  output wire [13:0] ctrl_reg, // control register
  output wire [5:0] mon_sel, // monitor channel select
  output wire soft_rst, // defaults and zero all dacs
  output wire busy_n, // busy, active low
  output wire pwr_down, // global power-down
  output wire amp_en, // amplifiers and refs up
  output wire out_hiz, // powered-down outputs float
  output wire out_gnd_load // powered-down outputs loaded
);
  // --------------------------------------------------------------
  // state codes
  // --------------------------------------------------------------
  localparam ST_IDLE = 4'b0001;
  localparam ST_RX = 4'b0010;
  localparam ST_ACK = 4'b0100;
  localparam ST_IGN = 4'b1000;
  localparam RL_ADR = 4'b0001;
  localparam RL_PTR = 4'b0010;
  localparam RL_D1 = 4'b0100;
  localparam RL_D2 = 4'b1000;

  wire [6:0] pin_s;
  wire scl_s;
  wire sda_s;
  wire clr_s;
  wire pd_s;
  wire sel_s;
  wire [1:0] strap_s;
  reg scl_q_ff;
  reg sda_q_ff;
  reg clr_q_ff;
  reg [3:0] state_ff;
  reg [3:0] role_ff;
  reg [3:0] cnt_ff;
  reg [7:0] sh_ff;
  reg [7:0] ptr_ff;
  reg [7:0] d1_ff;
  reg burst_ff;
  reg [3:0] bch_ff;
  reg sda_oe_ff;
  reg sda_out_ff;
  reg scl_out_ff;
  reg scl_oe_ff;
  reg wstb_ff;
  reg wab_ff;
  reg wrw_ff;
  reg [3:0] wch_ff;
  reg [15:0] wword_ff;

  // mask the top channel bit on the eight-channel build
  function [3:0] chan_map;
    input [3:0] ch;
    input v8;
    begin
      chan_map = v8 ? {1'b0, ch[2:0]} : ch;
    end
  endfunction

  // --------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------
  dis_sync #(
    .W(7),
    .INIT(7'h70) // only clock, data and clear idle high
  ) u_sync (
    .mclk(mclk),
    .rstn(rstn),
    .d({scl_in, sda_in, clear_pin_n, pd_pin, if_sel_spi,
        bus_addr_strap_hi, bus_addr_strap_lo}),
    .q(pin_s)
  );
  assign scl_s = pin_s[6];
  assign sda_s = pin_s[5];
  assign clr_s = pin_s[4];
  assign pd_s = pin_s[3];
  assign sel_s = pin_s[2];
  assign strap_s = pin_s[1:0];

  // previous filtered levels for edge finding
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
      clr_q_ff <= 1'b1;
    end
    else
    begin
      scl_q_ff <= scl_s;
      sda_q_ff <= sda_s;
      clr_q_ff <= clr_s;
    end
  end

  // bus conditions; data moves only with clock low otherwise
  wire scl_rise = scl_s & ~scl_q_ff;
  wire scl_fall = ~scl_s & scl_q_ff;
  wire start_det = scl_s & scl_q_ff & sda_q_ff & ~sda_s;
  wire stop_det = scl_s & scl_q_ff & ~sda_q_ff & sda_s;
  wire byte_done = scl_fall & (cnt_ff == `DIS_BYTE_BITS);
  wire addr_hit = (sh_ff[7:1] == {`DIS_ADDR_FIXED, strap_s});
  wire [3:0] last_ch = variant_8ch ? `DIS_LAST_CH8 : `DIS_LAST_CH16;

  // --------------------------------------------------------------
  // bus protocol engine
  // --------------------------------------------------------------
  // one engine decides ack and byte role, so a stop in the
  // middle of an update simply never reaches the write strobe
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_ff <= ST_IDLE;
      role_ff <= RL_ADR;
      cnt_ff <= 4'h0;
      sh_ff <= 8'h00;
      ptr_ff <= 8'h00;
      d1_ff <= 8'h00;
      burst_ff <= 1'b0;
      bch_ff <= 4'h0;
      sda_oe_ff <= 1'b0;
      sda_out_ff <= 1'b0;
      scl_out_ff <= 1'b0;
      scl_oe_ff <= 1'b0;
      wstb_ff <= 1'b0;
      wab_ff <= 1'b0;
      wrw_ff <= 1'b0;
      wch_ff <= 4'h0;
      wword_ff <= 16'h0000;
    end
    else
    begin
      wstb_ff <= 1'b0;
      scl_oe_ff <= 1'b0;
      if (sel_s)
      begin
        // port disabled while the other interface is chosen
        state_ff <= ST_IDLE;
        sda_oe_ff <= 1'b0;
        burst_ff <= 1'b0;
      end
      else if (start_det)
      begin
        // fresh or repeated start: listen for address again
        state_ff <= ST_RX;
        role_ff <= RL_ADR;
        cnt_ff <= 4'h0;
        sda_oe_ff <= 1'b0;
        burst_ff <= 1'b0;
      end
      else if (stop_det)
      begin
        state_ff <= ST_IDLE;
        sda_oe_ff <= 1'b0;
        burst_ff <= 1'b0;
      end
      else
      begin
        case (state_ff)
          ST_RX:
          begin
            if (scl_rise && cnt_ff != `DIS_BYTE_BITS)
            begin
              sh_ff <= {sh_ff[6:0], sda_s};
              cnt_ff <= cnt_ff + 4'h1;
            end
            else if (byte_done)
            begin
              cnt_ff <= 4'h0;
              state_ff <= ST_ACK;
              sda_oe_ff <= 1'b1;
              case (role_ff)
                RL_ADR:
                begin
                  if (addr_hit && !sh_ff[0])
                    role_ff <= RL_PTR;
                  else
                  begin
                    state_ff <= ST_IGN;
                    sda_oe_ff <= 1'b0;
                  end
                end
                RL_PTR:
                begin
                  if (sh_ff == `DIS_BURST_PTR)
                  begin
                    burst_ff <= 1'b1;
                    bch_ff <= 4'h0;
                  end
                  else
                    ptr_ff <= sh_ff;
                  role_ff <= RL_D1;
                end
                RL_D1:
                begin
                  d1_ff <= sh_ff;
                  role_ff <= RL_D2;
                end
                default:
                begin
                  // second data byte completes the update
                  wstb_ff <= 1'b1;
                  wword_ff <= {d1_ff, sh_ff};
                  if (burst_ff)
                  begin
                    wch_ff <= chan_map(bch_ff, variant_8ch);
                    wab_ff <= 1'b0;
                    wrw_ff <= 1'b0;
                    if (bch_ff == last_ch)
                    begin
                      burst_ff <= 1'b0;
                      role_ff <= RL_PTR;
                    end
                    else
                    begin
                      bch_ff <= bch_ff + 4'h1;
                      role_ff <= RL_D1;
                    end
                  end
                  else
                  begin
                    wch_ff <= ptr_ff[3:0];
                    wab_ff <= ptr_ff[`DIS_PTR_AB];
                    wrw_ff <= ptr_ff[`DIS_PTR_RW];
                    role_ff <= RL_PTR;
                  end
                end
              endcase
            end
          end
          ST_ACK:
          begin
            // low from end of bit eight through the ninth clock
            if (scl_fall)
            begin
              sda_oe_ff <= 1'b0;
              state_ff <= ST_RX;
            end
          end
          default:
          begin
            // idle or ignoring: wait for a start only
            sda_oe_ff <= 1'b0;
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------
  // command decoder
  // --------------------------------------------------------------
  wire is_sfr = (wword_ff[`DIS_REG_HI:`DIS_REG_LO] == 2'b00);
  wire sfr_go = wstb_ff & is_sfr & ~wrw_ff;
  wire nop_go = wstb_ff & is_sfr & (wch_ff == `DIS_SFR_NOP);
  wire sclr_go = sfr_go & (wch_ff == `DIS_SFR_SOFTCLR);
  wire srst_go = sfr_go & (wch_ff == `DIS_SFR_SRST);
  wire pin_clr = clr_q_ff & ~clr_s;
  wire busy_ld = nop_go | sclr_go;
  wire [`DIS_TMR_W-1:0] clr_cyc = variant_8ch ?
    `DIS_CLR8_CYC : `DIS_CLR16_CYC;
  // busy also drops in the load cycle, so the timer runs one short
  wire [`DIS_TMR_W-1:0] busy_val =
    (sclr_go ? clr_cyc : `DIS_NOP_CYC) - {{(`DIS_TMR_W-1){1'b0}}, 1'b1};
  wire busy_act;
  wire pu_act;
  reg soft_pd_ff;
  reg pwr_down_ff;
  reg amp_en_ff;
  reg out_hiz_ff;
  reg out_load_ff;
  reg busy_n_ff;
  reg dac_wr_ff;
  reg dac_ab_ff;
  reg [3:0] dac_ch_ff;
  reg [1:0] dac_reg_ff;
  reg [13:0] dac_data_ff;
  reg clr_all_ff;
  reg [13:0] clr_code_ff;
  reg [13:0] ctrl_ff;
  reg [5:0] mon_ff;
  reg srst_ff;
  wire pd_now = soft_pd_ff | pd_s;
  wire pu_ld = pwr_down_ff & ~pd_now;

  // busy timing for soft clear and idle command
  dis_tmr u_busy (
    .mclk(mclk),
    .rstn(rstn),
    .load(busy_ld),
    .val(busy_val),
    .act(busy_act)
  );

  // wake-up interval of amplifiers and references
  dis_tmr u_pup (
    .mclk(mclk),
    .rstn(rstn),
    .load(pu_ld),
    .val(`DIS_PU_CYC),
    .act(pu_act)
  );

  // register writes and special commands
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      dac_wr_ff <= 1'b0;
      dac_ab_ff <= 1'b0;
      dac_ch_ff <= 4'h0;
      dac_reg_ff <= 2'b00;
      dac_data_ff <= 14'h0000;
      clr_all_ff <= 1'b0;
      clr_code_ff <= `DIS_CLR_RST;
      ctrl_ff <= `DIS_CTRL_RST;
      mon_ff <= `DIS_MON_RST;
      soft_pd_ff <= 1'b0;
      srst_ff <= 1'b0;
    end
    else
    begin
      // read requests raise no write pulse but still load the dac fields, and an idle read sets busy
      dac_wr_ff <= wstb_ff & ~is_sfr & ~wrw_ff;
      if (wstb_ff && !is_sfr)
      begin
        dac_ab_ff <= wab_ff;
        dac_ch_ff <= chan_map(wch_ff, variant_8ch);
        dac_reg_ff <= wword_ff[`DIS_REG_HI:`DIS_REG_LO];
        dac_data_ff <= wword_ff[13:0];
      end
      clr_all_ff <= sclr_go | pin_clr;
      srst_ff <= srst_go;
      if (srst_go)
      begin
        clr_code_ff <= `DIS_CLR_RST;
        ctrl_ff <= `DIS_CTRL_RST;
        mon_ff <= `DIS_MON_RST;
        soft_pd_ff <= 1'b0;
      end
      else if (sfr_go)
      begin
        case (wch_ff)
          `DIS_SFR_CLRCODE: clr_code_ff <= wword_ff[13:0];
          `DIS_SFR_PDOWN: soft_pd_ff <= 1'b1;
          `DIS_SFR_PUP: soft_pd_ff <= 1'b0;
          `DIS_SFR_MON: mon_ff <= wword_ff[`DIS_MON_HI:`DIS_MON_LO];
          `DIS_SFR_CTRL: ctrl_ff <= wword_ff[13:0];
          default: soft_pd_ff <= soft_pd_ff;
        endcase
      end
    end
  end

  // power state and status; contents survive power-down
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      pwr_down_ff <= 1'b0;
      amp_en_ff <= 1'b0;
      out_hiz_ff <= 1'b0;
      out_load_ff <= 1'b0;
      busy_n_ff <= 1'b1;
    end
    else
    begin
      pwr_down_ff <= pd_now;
      amp_en_ff <= ~pd_now & ~pwr_down_ff & ~pu_act;
      out_hiz_ff <= pd_now & pd_hiz_cfg;
      out_load_ff <= pd_now & ~pd_hiz_cfg;
      busy_n_ff <= ~(busy_ld | busy_act);
    end
  end

  assign scl_out = scl_out_ff;
  assign scl_oe = scl_oe_ff;
  assign sda_out = sda_out_ff;
  assign sda_oe = sda_oe_ff;
  assign dac_wr = dac_wr_ff;
  assign dac_ab = dac_ab_ff;
  assign dac_ch = dac_ch_ff;
  assign dac_reg = dac_reg_ff;
  assign dac_data = dac_data_ff;
  assign clr_all = clr_all_ff;
  assign clr_code = clr_code_ff;
  assign ctrl_reg = ctrl_ff;
  assign mon_sel = mon_ff;
  assign soft_rst = srst_ff;
  assign busy_n = busy_n_ff;
  assign pwr_down = pwr_down_ff;
  assign amp_en = amp_en_ff;
  assign out_hiz = out_hiz_ff;
  assign out_gnd_load = out_load_ff;
endmodule // dis_top

/* File: sim/dis_mst.sv */
// two-wire bus master model that drives the command port
`timescale 1ns/10ps
module dis_mst (
  input wire sda, // resolved data line
  output logic scl_low, // pull clock line low
  output logic sda_low // pull data line low
);
  // both lines released until the first transfer
  initial
  begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // start from idle, or repeated start from a low clock; clock left low
  task automatic start();
    sda_low = 1'b0;
    #40 scl_low = 1'b0;
    #80 sda_low = 1'b1;
    #80 scl_low = 1'b1;
    #80;
  endtask
  // stop from a low clock; clock then stands still high
  task automatic stop();
    #40 sda_low = 1'b1;
    #40 scl_low = 1'b0;
    #80 sda_low = 1'b0;
    #80;
  endtask
  // one byte msb first at a 160 ns bit period, then the ninth clock
  task automatic wbyte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      #40 sda_low = ~b[i];
      #40 scl_low = 1'b0;
      #80 scl_low = 1'b1;
    end
    // ninth clock held low longer so the synced ack drive settles
    #40 sda_low = 1'b0;
    #120 scl_low = 1'b0;
    #80 ack = ~sda;
    scl_low = 1'b1;
    #160;
  endtask
endmodule // dis_mst

/* File: sim/dis_top_chk.sv */
// assertion checker for the two-wire dac command port
`timescale 1ns/10ps
module dis_top_chk (
  input wire mclk, // system clock
  input wire rstn, // async reset, active low
  input wire scl_oe, // clock drive enable
  input wire sda_oe, // data drive enable
  input wire if_sel_spi, // interface select
  input wire clear_pin_n, // clear pin
  input wire pd_pin, // power-down pin
  input wire pd_hiz_cfg, // float choice
  input wire clr_all, // clear pulse
  input wire busy_n, // busy, active low
  input wire pwr_down, // global power-down
  input wire amp_en, // amplifiers up
  input wire out_hiz, // outputs float
  input wire out_gnd_load // outputs loaded
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  logic [10:0] bcnt_ff;
  logic [8:0] ucnt_ff;
  // busy low-time meter; wake timer starts near 400 so reset needs no wait
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      bcnt_ff <= 11'h000;
      ucnt_ff <= 9'h190;
    end
    else
    begin
      bcnt_ff <= busy_n ? 11'h000 : bcnt_ff + 11'h001;
      ucnt_ff <= pwr_down ? 9'h000 : ucnt_ff + {8'h00, ucnt_ff != 9'h1ff};
    end
  end
  // ----------------------------------------
  // bus side
  // ----------------------------------------
  a_clk_not_driven: assert property (!scl_oe)
    else $error("clock line driven");
  a_spi_no_ack: assert property (if_sel_spi [*8] |-> !sda_oe)
    else $error("ack while port deselected");
  a_ack_held: assert property ($rose(sda_oe) |-> sda_oe [*6])
    else $error("ack too short");
  // ----------------------------------------
  // command side
  // ----------------------------------------
  a_busy_low_len: assert property ($rose(busy_n) |->
    bcnt_ff inside {11'h001, 11'h2ee, 11'h3e8})
    else $error("busy low time wrong");
  a_pin_clear: assert property ($fell(clear_pin_n) |-> ##[2:7] clr_all)
    else $error("pin clear missed");
  a_pin_pd: assert property (pd_pin [*8] |-> pwr_down)
    else $error("pin power-down missed");
  a_pd_amp_off: assert property (pwr_down [*2] |-> !amp_en)
    else $error("amplifier on while down");
  a_wake_early: assert property ($rose(amp_en) |-> ucnt_ff > 9'h186)
    else $error("wake too early");
  a_wake_late: assert property (!pwr_down && ucnt_ff > 9'h19a |-> amp_en)
    else $error("wake too late");
  a_pd_outs: assert property (pwr_down [*2] ##0 $stable(pd_hiz_cfg) |->
    out_hiz == pd_hiz_cfg && out_gnd_load == !pd_hiz_cfg)
    else $error("powered-down output mode wrong");
  a_up_outs_off: assert property (!pwr_down [*2] |-> !out_hiz && !out_gnd_load)
    else $error("output mode set while up");
  c_soft_clear: cover property ($rose(busy_n) && bcnt_ff == 11'h3e8);
  c_pin_clear: cover property (clr_all && !clear_pin_n);
  c_wake: cover property ($rose(amp_en) && ucnt_ff < 9'h1f0);
endmodule // dis_top_chk

bind dis_top dis_top_chk i_chk (.mclk(mclk), .rstn(rstn), .scl_oe(scl_oe),
  .sda_oe(sda_oe), .if_sel_spi(if_sel_spi), .clear_pin_n(clear_pin_n),
  .pd_pin(pd_pin), .pd_hiz_cfg(pd_hiz_cfg), .clr_all(clr_all),
  .busy_n(busy_n), .pwr_down(pwr_down), .amp_en(amp_en), .out_hiz(out_hiz),
  .out_gnd_load(out_gnd_load));

/* File: sim/tb_dis_top.sv */
// self-checking bench for the two-wire dac command port
`timescale 1ns/10ps
`include "dis_defs.vh"
module tb_dis_top;
  logic mclk, rstn, if_sel_spi, st_hi, st_lo, clear_pin_n, pd_pin;
  logic variant_8ch, pd_hiz_cfg, scl_low, sda_low, ack;
  wire scl_out, scl_oe, sda_out, sda_oe, dac_wr, dac_ab, clr_all, soft_rst;
  wire busy_n, pwr_down, amp_en, out_hiz, out_gnd_load;
  wire [3:0] dac_ch;
  wire [1:0] dac_reg;
  wire [13:0] dac_data, clr_code, ctrl_reg;
  wire [5:0] mon_sel;
  int n_mismatch, n_compared, seed, nwr, nclr, nsr, bcnt, blen, t, n;
  logic [7:0] p, d1, d2;
  // open-drain lines with pull-ups; any low driver wins
  wire scl = ~(scl_low | (scl_oe & ~scl_out));
  wire sda = ~(sda_low | (sda_oe & ~sda_out));
  dis_top i_dut (.mclk(mclk), .rstn(rstn), .scl_in(scl), .sda_in(sda),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe),
    .if_sel_spi(if_sel_spi), .bus_addr_strap_hi(st_hi),
    .bus_addr_strap_lo(st_lo), .clear_pin_n(clear_pin_n), .pd_pin(pd_pin),
    .variant_8ch(variant_8ch), .pd_hiz_cfg(pd_hiz_cfg), .dac_wr(dac_wr),
    .dac_ab(dac_ab), .dac_ch(dac_ch), .dac_reg(dac_reg), .dac_data(dac_data),
    .clr_all(clr_all), .clr_code(clr_code), .ctrl_reg(ctrl_reg),
    .mon_sel(mon_sel), .soft_rst(soft_rst), .busy_n(busy_n),
    .pwr_down(pwr_down), .amp_en(amp_en), .out_hiz(out_hiz),
    .out_gnd_load(out_gnd_load));
  dis_mst i_mst (.sda(sda), .scl_low(scl_low), .sda_low(sda_low));
  // 50 MHz system clock
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // pulse counters and busy low-time meter
  always @(posedge mclk)
  begin
    nwr += (dac_wr === 1'b1);
    nclr += (clr_all === 1'b1);
    nsr += (soft_rst === 1'b1);
    if (busy_n === 1'b0)
      bcnt++;
    else if (bcnt != 0)
    begin
      blen = bcnt;
      bcnt = 0;
    end
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string w, input [23:0] e, g);
    n_compared++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // bounded wait for amplifiers up or busy released
  task automatic wt(input int m, input logic amp);
    t = 0;
    while ((amp ? amp_en : busy_n) !== 1'b1 && t < m)
    begin
      @(posedge mclk);
      t++;
    end
    chk("wait bound", 1, t < m);
    if (t >= m)
      finish_test();
    repeat (2) @(posedge mclk);
  endtask
  task automatic xb(input [7:0] b, input logic e);
    i_mst.wbyte(b, ack);
    chk("ack", e, ack);
  endtask
  function automatic [7:0] adr(input logic rw);
    return {`DIS_ADDR_FIXED, st_hi, st_lo, rw};
  endfunction
  // two data bytes, then the write they must produce
  task automatic pair(input [7:0] a, b, input logic ab, input [3:0] ch);
    n = nwr;
    xb(a, 1'b1);
    xb(b, 1'b1);
    chk("writes", n + 1, nwr);
    chk("fields", {ab, ch, a, b}, {dac_ab, dac_ch, dac_reg, dac_data});
  endtask
  task automatic rnd();
    p = $random(seed);
    p[6:4] = 3'h0;
    p[3] = p[3] & ~variant_8ch;
    d1 = $random(seed);
    d1[6] = d1[6] | ~d1[7];
    d2 = $random(seed);
  endtask
  task automatic cmd(input [3:0] c, input [13:0] d);
    @(negedge mclk);
    i_mst.start();
    xb(adr(1'b0), 1'b1);
    xb({4'h0, c}, 1'b1);
    xb({2'b00, d[13:8]}, 1'b1);
    xb(d[7:0], 1'b1);
    i_mst.stop();
    repeat (4) @(posedge mclk);
  endtask
  // watchdog against a hung run
  initial
  begin
    #1500000;
    chk("run time", 0, 1);
    finish_test();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    seed = 39497;
    {rstn, if_sel_spi, st_hi, st_lo, pd_pin, variant_8ch, pd_hiz_cfg} = '0;
    clear_pin_n = 1'b1;
    repeat (10) @(posedge mclk);
    @(negedge mclk) rstn = 1'b1;
    repeat (8) @(posedge mclk);
    chk("reset regs", 24'h0, {clr_code, ctrl_reg[9:0]});
    chk("busy_n", 1, busy_n);
    for (int s = 0; s < 4; s++)
    begin
      @(negedge mclk) {st_hi, st_lo} = s[1:0];
      repeat (8) @(negedge mclk);
      i_mst.start();
      xb(adr(1'b0) ^ 8'h04, 1'b0);
      xb(8'h00, 1'b0);
      i_mst.start();
      xb(adr(1'b1), 1'b0);
      i_mst.start();
      xb(adr(1'b0), 1'b1);
      i_mst.start();
      xb(adr(1'b0), 1'b1);
      i_mst.stop();
    end
    for (int v = 0; v < 2; v++)
    begin
      @(negedge mclk) variant_8ch = v[0];
      i_mst.start();
      xb(adr(1'b0), 1'b1);
      repeat (6)
      begin
        rnd();
        xb(p, 1'b1);
        pair(d1, d2, p[7], p[3:0]);
      end
      rnd();
      xb(p, 1'b1);
      xb(d1, 1'b1);
      i_mst.start();
      xb(adr(1'b0), 1'b1);
      xb(p, 1'b1);
      xb(d1, 1'b1);
      i_mst.stop();
      chk("aborted", n + 1, nwr);
      i_mst.start();
      xb(adr(1'b0), 1'b1);
      xb(`DIS_BURST_PTR, 1'b1);
      for (int c = 0; c <= (v ? 7 : 15); c++)
      begin
        rnd();
        pair(d1, d2, 1'b0, c[3:0]);
      end
      rnd();
      xb(p, 1'b1);
      pair(d1, d2, p[7], p[3:0]);
      i_mst.stop();
      n = nclr;
      cmd(4'h2, 14'h0000);
      wt(1200, 1'b0);
      chk("clear pulses", n + 1, nclr);
      chk("busy low", v ? 24'h2ee : 24'h3e8, blen);
    end
    d1 = $random(seed);
    d2 = $random(seed);
    cmd(4'h1, {d1[5:0], d2});
    chk("clr_code", {d1[5:0], d2}, clr_code);
    cmd(4'hc, {d2[5:0], d1});
    chk("ctrl_reg", {d2[5:0], d1}, ctrl_reg);
    cmd(4'ha, {d2[7:2], d1});
    chk("mon_sel", d2[7:2], mon_sel);
    cmd(4'h0, 14'h3fff);
    chk("idle busy", 1, blen);
    cmd(4'h5, 14'h3fff);
    chk("regs kept", {d1[5:0], d2, d2[7:2]}, {clr_code, mon_sel});
    cmd(4'h8, 14'h0000);
    chk("power down", 3'h5, {pwr_down, out_hiz, out_gnd_load});
    chk("clr kept", {d1[5:0], d2}, clr_code);
    @(negedge mclk) pd_hiz_cfg = 1'b1;
    @(negedge mclk) pd_pin = 1'b1;
    repeat (8) @(posedge mclk);
    chk("float mode", 3'h6, {pwr_down, out_hiz, out_gnd_load});
    @(negedge mclk) pd_pin = 1'b0;
    repeat (8) @(posedge mclk);
    chk("soft down kept", 1, pwr_down);
    cmd(4'h9, 14'h0000);
    chk("amp early", 2'h0, {pwr_down, amp_en});
    wt(600, 1'b1);
    chk("wake time", 1, t > 340);
    n = nclr;
    @(negedge mclk) clear_pin_n = 1'b0;
    repeat (12) @(posedge mclk);
    chk("pin clear", n + 1, nclr);
    @(negedge mclk) clear_pin_n = 1'b1;
    n = nsr;
    cmd(4'hf, 14'h3fff);
    chk("soft resets", n + 1, nsr);
    chk("defaults", 24'h0, {clr_code, mon_sel});
    chk("ctrl default", 24'h0, ctrl_reg);
    @(negedge mclk) if_sel_spi = 1'b1;
    repeat (8) @(negedge mclk);
    i_mst.start();
    xb(adr(1'b0), 1'b0);
    i_mst.stop();
    finish_test();
  end
endmodule // tb_dis_top
